// ---- logic/dpct_top.sv ----
// dual prescaled counter/timers with external input roles and request flags
// assumes configuration ports are static while counting and commands are
// one-cycle codes on core_clk_in; port-three lines are asynchronous pins
//
// Operation
// - two independent 8-bit down counters, each behind its own 6-bit prescaler
// - first prescaler fed only internally; second internally or externally
// - each prescaler divides its input by any integer 1 through 64
// - counter decrements once per prescaler pulse from loaded value, 1 to 256 counts
// - end of count raises that timer's request
// - software can start, stop, resume or restart a counter from initial value
// - single-pass mode halts at zero without reload
// - modulo-n mode reloads initial value and keeps counting
// - counter reads never disturb count or mode; prescalers are not readable
// - second timer clock: core clock divided by four or the external pin
// - external pin acts as clock, retrigger, non-retrigger trigger or gate
// - cascading lets first timer's end of count clock the second timer
// - external input mode enabled when the mode select bit is zero
// - six maskable prioritized requests: four port lines and two timers
// - each request masked individually, and all gated globally
// - first prescaler setting is write-only
// - timer pin shares a request with its port line, both edges trigger
`timescale 1ns/1ps
module dpct_top #(
  parameter int CNT_W = dpct_pkg::CNT_W,
  parameter int PRE_W = dpct_pkg::PRE_W
) (
  input  wire logic                          core_clk_in,
  input  wire logic                          arst_n_in,
  input  wire logic [CNT_W-1:0]              t0_load_value_in,
  input  wire logic                          t0_load_in,
  input  wire logic [PRE_W-1:0]              t0_divisor_in,
  input  wire logic                          t0_continuous_in,
  input  wire logic [1:0]                    t0_cmd_in,
  input  wire logic [CNT_W-1:0]              t1_load_value_in,
  input  wire logic                          t1_load_in,
  input  wire logic [PRE_W-1:0]              t1_divisor_in,
  input  wire logic                          t1_continuous_in,
  input  wire logic [1:0]                    t1_cmd_in,
  input  wire logic                          input_mode_select_bit_in,
  input  wire logic [1:0]                    t1_input_role_in,
  input  wire logic                          cascade_in,
  input  wire logic [dpct_pkg::NUM_PORT-1:0] port_three_request_lines_in,
  input  wire logic [dpct_pkg::NUM_REQ-1:0]  request_mask_in,
  input  wire logic                          request_global_enable_in,
  input  wire logic [dpct_pkg::NUM_REQ-1:0]  request_clear_in,
  output logic [CNT_W-1:0]                   t0_count_out,
  output logic [CNT_W-1:0]                   t1_count_out,
  output logic                               t0_running_out,
  output logic                               t1_running_out,
  output logic [dpct_pkg::NUM_REQ-1:0]       request_pending_out,
  output logic                               interrupt_out,
  output logic [dpct_pkg::REQ_IDX_W-1:0]     interrupt_index_out
);

  initial begin
    if (CNT_W != dpct_pkg::CNT_W) $error("dpct_top: CNT_W must match package width");
    if (PRE_W != dpct_pkg::PRE_W) $error("dpct_top: PRE_W must match package width");
  end

  // =====================================================================
  // lowest set bit wins: request 0 has the highest priority
  // fixed order, no rotation
  function automatic logic [dpct_pkg::REQ_IDX_W-1:0] first_set(
    input logic [dpct_pkg::NUM_REQ-1:0] vec
  );
    logic [dpct_pkg::REQ_IDX_W-1:0] idx;
    idx = '0;
    // scan down so the lowest set bit stays
    for (int i = dpct_pkg::NUM_REQ - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = i[dpct_pkg::REQ_IDX_W-1:0];
      end
    end
    return idx;
  endfunction

  // =====================================================================
  // pin synchronisers: a change counts once the second and third stages agree
  logic [dpct_pkg::NUM_PORT-1:0] sync1_reg;
  logic [dpct_pkg::NUM_PORT-1:0] sync2_reg;
  logic [dpct_pkg::NUM_PORT-1:0] sync3_reg;
  logic [dpct_pkg::NUM_PORT-1:0] level_reg;
  logic [dpct_pkg::NUM_PORT-1:0] pin_rise;
  logic [dpct_pkg::NUM_PORT-1:0] pin_fall;
  logic [dpct_pkg::NUM_PORT-1:0] line_event;

  // reset to the idle-high pin level
  // so no false edge follows reset
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      sync3_reg <= '1;
    end else begin
      sync1_reg <= port_three_request_lines_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < dpct_pkg::NUM_PORT; g++) begin : g_line
      always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          level_reg[g] <= 1'b1;
        end else if (sync2_reg[g] == sync3_reg[g]) begin
          level_reg[g] <= sync3_reg[g];
        end
      end
      // counts once stages two and three agree
      assign pin_rise[g]   = (sync2_reg[g] == sync3_reg[g]) && sync3_reg[g] && !level_reg[g];
      assign pin_fall[g]   = (sync2_reg[g] == sync3_reg[g]) && !sync3_reg[g] && level_reg[g];
      assign line_event[g] = (pin_rise[g] && dpct_pkg::PORT_RISE_EN[g])
                           || (pin_fall[g] && dpct_pkg::PORT_FALL_EN[g]);
    end
  endgenerate

  // =====================================================================
  // internal timebase: core clock over four
  // never restarted: a command lands
  // anywhere in the four-clock phase
  logic [dpct_pkg::INT_DIV_W-1:0] int_div_reg;
  logic                           int_tick;

  assign int_tick = (int_div_reg == dpct_pkg::INT_DIV_W'(dpct_pkg::INT_DIV - 1));

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      int_div_reg <= '0;
    end else begin
      int_div_reg <= int_tick ? '0 : int_div_reg + 1'b1;
    end
  end

  // =====================================================================
  // command decode
  // a held code acts on every edge
  // so a held restart pins the count
  logic t0_restart;
  logic t0_stop;
  logic t0_resume;
  logic t1_restart;
  logic t1_stop;
  logic t1_resume;
  logic t1_trigger;
  logic t0_active;
  logic t1_active;

  assign t0_restart = (t0_cmd_in == 2'(dpct_pkg::DPCT_CMD_RESTART));
  assign t0_stop    = (t0_cmd_in == 2'(dpct_pkg::DPCT_CMD_STOP));
  assign t0_resume  = (t0_cmd_in == 2'(dpct_pkg::DPCT_CMD_RESUME));
  assign t1_stop    = (t1_cmd_in == 2'(dpct_pkg::DPCT_CMD_STOP));
  assign t1_resume  = (t1_cmd_in == 2'(dpct_pkg::DPCT_CMD_RESUME));
  assign t1_restart = (t1_cmd_in == 2'(dpct_pkg::DPCT_CMD_RESTART)) || t1_trigger;

  // =====================================================================
  // second timer source selection and external input roles
  // cascade overrides the clock and gate pin roles
  // pin triggers still restart the second timer in trigger roles
  logic ext_mode;
  logic ext_fall;
  logic ext_level;
  logic t0_end;
  logic t1_end;
  logic t1_src_tick;

  assign ext_mode  = (input_mode_select_bit_in == dpct_pkg::EXT_MODE_ON);
  assign ext_fall  = pin_fall[dpct_pkg::PIN_TIMER];
  assign ext_level = level_reg[dpct_pkg::PIN_TIMER];

  // a non-retriggerable trigger is ignored while the count is still running
  // triggers use the filtered fall
  always_comb begin
    t1_trigger = 1'b0;
    if (ext_mode && ext_fall) begin
      case (t1_input_role_in)
        2'(dpct_pkg::DPCT_ROLE_RETRIG):    t1_trigger = 1'b1;
        2'(dpct_pkg::DPCT_ROLE_NONRETRIG): t1_trigger = !t1_active;
        default:                           t1_trigger = 1'b0;
      endcase
    end
  end

  // gate opens 3-4 clocks after the pin
  always_comb begin
    t1_src_tick = int_tick;
    if (cascade_in) begin
      t1_src_tick = t0_end;
    end else if (ext_mode) begin
      case (t1_input_role_in)
        2'(dpct_pkg::DPCT_ROLE_CLOCK): t1_src_tick = ext_fall;
        2'(dpct_pkg::DPCT_ROLE_GATE):  t1_src_tick = int_tick && ext_level;
        default:                       t1_src_tick = int_tick;
      endcase
    end
  end

  // =====================================================================
  // the two timers; prescaler settings have no read path at all
  // load/restart clear the prescaler
  // phase: first period is a full one
  logic t0_pre_pulse;
  logic t1_pre_pulse;

  // first timer: internal tick only
  dpct_prescaler #(.PRE_W(PRE_W)) u_pre0 (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .tick_in     (int_tick),
    .restart_in  (t0_load_in || t0_restart),
    .divisor_in  (t0_divisor_in),
    .pulse_out   (t0_pre_pulse)
  );

  // reads of count never touch the state
  dpct_counter #(.CNT_W(CNT_W)) u_cnt0 (
    .core_clk_in   (core_clk_in),
    .arst_n_in     (arst_n_in),
    .tick_in       (t0_pre_pulse),
    .load_in       (t0_load_in),
    .load_value_in (t0_load_value_in),
    .restart_in    (t0_restart),
    .stop_in       (t0_stop),
    .resume_in     (t0_resume),
    .continuous_in (t0_continuous_in),
    .count_out     (t0_count_out),
    .active_out    (t0_active),
    .end_out       (t0_end)
  );

  // second timer: source picked above
  dpct_prescaler #(.PRE_W(PRE_W)) u_second_prescaler_reg (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .tick_in     (t1_src_tick),
    .restart_in  (t1_load_in || t1_restart),
    .divisor_in  (t1_divisor_in),
    .pulse_out   (t1_pre_pulse)
  );

  dpct_counter #(.CNT_W(CNT_W)) u_cnt1 (
    .core_clk_in   (core_clk_in),
    .arst_n_in     (arst_n_in),
    .tick_in       (t1_pre_pulse),
    .load_in       (t1_load_in),
    .load_value_in (t1_load_value_in),
    .restart_in    (t1_restart),
    .stop_in       (t1_stop),
    .resume_in     (t1_resume),
    .continuous_in (t1_continuous_in),
    .count_out     (t1_count_out),
    .active_out    (t1_active),
    .end_out       (t1_end)
  );

  // running is the counter's own flag
  assign t0_running_out = t0_active;
  assign t1_running_out = t1_active;

  // =====================================================================
  // request flags: a new event wins over a clear in the same cycle
  // masking never clears a flag, so
  // software can poll masked requests
  logic [dpct_pkg::NUM_REQ-1:0] req_event;
  logic [dpct_pkg::NUM_REQ-1:0] pending_reg;
  logic [dpct_pkg::NUM_REQ-1:0] enabled;

  always_comb begin
    req_event                     = '0;
    req_event[dpct_pkg::REQ_LINE0] = line_event[0];
    req_event[dpct_pkg::REQ_LINE1] = line_event[1];
    req_event[dpct_pkg::REQ_LINE2] = line_event[2];
    req_event[dpct_pkg::REQ_LINE3] = line_event[3];
    req_event[dpct_pkg::REQ_T0]    = t0_end;
    req_event[dpct_pkg::REQ_T1]    = t1_end;
  end

  // one flag per request, cleared by bit
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pending_reg <= dpct_pkg::REQ_RST;
    end else begin
      pending_reg <= (pending_reg & ~request_clear_in) | req_event;
    end
  end

  assign request_pending_out = pending_reg;
  // global enable gates every request
  assign enabled = pending_reg & request_mask_in & {dpct_pkg::NUM_REQ{request_global_enable_in}};

  // level and index change together
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interrupt_out       <= 1'b0;
      interrupt_index_out <= '0;
    end else begin
      interrupt_out       <= |enabled;
      interrupt_index_out <= first_set(enabled);
    end
  end

endmodule

// ---- logic/dpct_pkg.sv ----
// shared constants and types for the dual prescaled counter/timer block
// assumes one core clock; all users refer to names as dpct_pkg::name
package dpct_pkg;

  // =====================================================================
  // widths
  localparam int CNT_W    = 8;
  localparam int PRE_W    = 6;
  localparam int NUM_PORT = 4;
  localparam int NUM_REQ  = 6;
  localparam int REQ_IDX_W = 3;

  // =====================================================================
  // timing: the second timer's internal source is the core clock over four
  localparam int INT_DIV   = 4;
  localparam int INT_DIV_W = 2;

  // =====================================================================
  // port-three lines: index 0..3 are pins 0..3; pin 1 doubles as timer input
  localparam int PIN_TIMER = 1;
  // edge sensitivity per line, bit i = line i
  localparam logic [NUM_PORT-1:0] PORT_RISE_EN = 4'h6;
  localparam logic [NUM_PORT-1:0] PORT_FALL_EN = 4'hF;
  // request numbers of each line and of the two timers
  localparam int REQ_LINE0 = 3;
  localparam int REQ_LINE1 = 2;
  localparam int REQ_LINE2 = 0;
  localparam int REQ_LINE3 = 1;
  localparam int REQ_T0    = 4;
  localparam int REQ_T1    = 5;

  // =====================================================================
  // configuration encodings and reset values
  localparam logic EXT_MODE_ON = 1'b0;
  localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_ONE = 8'h01;
  localparam logic [PRE_W-1:0] PRE_RST   = 6'h00;
  localparam logic [NUM_REQ-1:0] REQ_RST = 6'h00;

  typedef enum logic [1:0] {
    DPCT_ROLE_CLOCK,
    DPCT_ROLE_RETRIG,
    DPCT_ROLE_NONRETRIG,
    DPCT_ROLE_GATE
  } dpct_role_t;

  typedef enum logic [1:0] {
    DPCT_CMD_NONE,
    DPCT_CMD_STOP,
    DPCT_CMD_RESUME,
    DPCT_CMD_RESTART
  } dpct_cmd_t;

endpackage

// ---- logic/dpct_prescaler.sv ----
// programmable prescaler: divides incoming tick pulses by 1..64
// assumes tick_in and restart_in are one-cycle pulses on core_clk_in
`timescale 1ns/1ps
module dpct_prescaler #(
  parameter int PRE_W = dpct_pkg::PRE_W
) (
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             tick_in,
  input  wire logic             restart_in,
  input  wire logic [PRE_W-1:0] divisor_in,
  output logic                  pulse_out
);

  initial begin
    if (PRE_W < 1 || PRE_W > 16) $error("dpct_prescaler: PRE_W out of range");
  end

  logic [PRE_W-1:0] phase_reg;
  logic [PRE_W-1:0] last_phase;

  // a divisor code of zero wraps to all ones, giving the full 2**PRE_W division
  assign last_phase = divisor_in - {{(PRE_W-1){1'b0}}, 1'b1};
  assign pulse_out  = tick_in && !restart_in && (phase_reg == last_phase);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_reg <= '0;
    end else if (restart_in) begin
      phase_reg <= '0;
    end else if (tick_in) begin
      phase_reg <= (phase_reg == last_phase) ? '0 : phase_reg + 1'b1;
    end
  end

endmodule

// ---- logic/dpct_counter.sv ----
// 8-bit down counter with initial-value register, single-pass and modulo-n modes
// assumes all strobes are one-cycle pulses on core_clk_in
`timescale 1ns/1ps
module dpct_counter #(
  parameter int CNT_W = dpct_pkg::CNT_W
) (
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             tick_in,
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] load_value_in,
  input  wire logic             restart_in,
  input  wire logic             stop_in,
  input  wire logic             resume_in,
  input  wire logic             continuous_in,
  output logic [CNT_W-1:0]      count_out,
  output logic                  active_out,
  output logic                  end_out
);

  initial begin
    if (CNT_W < 2 || CNT_W > 16) $error("dpct_counter: CNT_W out of range");
  end

  logic [CNT_W-1:0] init_reg;
  logic [CNT_W-1:0] count_reg;
  logic             active_reg;
  logic             at_one;

  assign at_one     = (count_reg == {{(CNT_W-1){1'b0}}, 1'b1});
  assign end_out    = tick_in && active_reg && at_one && !restart_in && !stop_in;
  assign count_out  = count_reg;
  assign active_out = active_reg;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      init_reg <= '0;
    end else if (load_in) begin
      init_reg <= load_value_in;
    end
  end

  // zero as initial value means 256 counts: it decrements through 255 down to one
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_reg <= '0;
    end else if (load_in) begin
      count_reg <= load_value_in;
    end else if (restart_in) begin
      count_reg <= init_reg;
    end else if (tick_in && active_reg && !stop_in) begin
      if (at_one) begin
        count_reg <= continuous_in ? init_reg : '0;
      end else begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      active_reg <= 1'b0;
    end else if (restart_in) begin
      active_reg <= 1'b1;
    end else if (stop_in) begin
      active_reg <= 1'b0;
    end else if (resume_in) begin
      active_reg <= (count_reg != '0);
    end else if (end_out && !continuous_in) begin
      active_reg <= 1'b0;
    end
  end

endmodule

// ---- dv/dpct_checker.sv ----
// concurrent checks on the ports of the dual counter/timer top
// assumes one core clock and the active-low asynchronous reset of the top
`timescale 1ns/1ps
module dpct_checker #(
  parameter int CNT_W = dpct_pkg::CNT_W
) (
  input wire logic                         core_clk_in,
  input wire logic                         arst_n_in,
  input wire logic [CNT_W-1:0]             t0_load_value_in,
  input wire logic                         t0_load_in,
  input wire logic [1:0]                   t0_cmd_in,
  input wire logic                         t1_load_in,
  input wire logic [1:0]                   t1_cmd_in,
  input wire logic [dpct_pkg::NUM_REQ-1:0] request_mask_in,
  input wire logic                         request_global_enable_in,
  input wire logic [dpct_pkg::NUM_REQ-1:0] request_clear_in,
  input wire logic [CNT_W-1:0]             t0_count_out,
  input wire logic                         t0_running_out,
  input wire logic                         t1_running_out,
  input wire logic [dpct_pkg::NUM_REQ-1:0] request_pending_out,
  input wire logic                         interrupt_out,
  input wire logic [dpct_pkg::REQ_IDX_W-1:0] interrupt_index_out
);
  // ======================================================================
  // sequences
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_t0_quiet;
    t0_cmd_in == 2'h0 && !t0_load_in;
  endsequence
  sequence s_t0_last_step;
    (t0_running_out ##0 s_t0_quiet) ##1 !t0_running_out;
  endsequence
  // ======================================================================
  // assertions
  a_irq_follows_enable: assert property (1'b1 |-> interrupt_out ==
    $past(|(request_pending_out & request_mask_in) && request_global_enable_in)) else $error("interrupt level wrong");
  a_irq_lowest_index: assert property (interrupt_out |->
    (($past(request_pending_out & request_mask_in) >> interrupt_index_out) & 6'h01) == 6'h01 &&
    ($past(request_pending_out & request_mask_in) & ((6'h01 << interrupt_index_out) - 6'h01)) == 6'h00)
    else $error("interrupt index not highest priority");
  a_t0_load_value: assert property (t0_load_in |=> t0_count_out == $past(t0_load_value_in))
    else $error("load value not taken");
  a_t0_stop_halts: assert property (t0_cmd_in == 2'h1 && !t0_load_in |=> !t0_running_out)
    else $error("first timer still running after stop");
  a_t1_stop_halts: assert property (t1_cmd_in == 2'h1 && !t1_load_in |=> !t1_running_out)
    else $error("second timer still running after stop");
  a_t0_idle_hold: assert property (!t0_running_out ##0 s_t0_quiet |=> $stable(t0_count_out) && !t0_running_out)
    else $error("idle count moved");
  a_t0_one_step: assert property (t0_running_out && t0_count_out > 8'h01 ##0 s_t0_quiet |=>
    (t0_count_out == $past(t0_count_out) || t0_count_out == $past(t0_count_out) - 8'h01))
    else $error("count moved by more than one");
  a_t0_single_end: assert property (s_t0_last_step |-> t0_count_out == 8'h00 && request_pending_out[4])
    else $error("single pass did not end at zero with request");
  a_t0_req_sticky: assert property (request_pending_out[4] && !request_clear_in[4] |=> request_pending_out[4])
    else $error("first timer request lost");
  a_t1_req_sticky: assert property (request_pending_out[5] && !request_clear_in[5] |=> request_pending_out[5])
    else $error("second timer request lost");
endmodule

bind dpct_top dpct_checker #(.CNT_W(CNT_W)) dpct_checker_i (
  .core_clk_in, .arst_n_in, .t0_load_value_in, .t0_load_in, .t0_cmd_in, .t1_load_in, .t1_cmd_in,
  .request_mask_in, .request_global_enable_in, .request_clear_in, .t0_count_out, .t0_running_out,
  .t1_running_out, .request_pending_out, .interrupt_out, .interrupt_index_out
);

// ---- dv/dpct_pin_model.sv ----
// model of the port-three pins, one of which is the external timer input
// assumes the bench calls its tasks; pins idle high as pulled-up inputs
`timescale 1ns/1ps
module dpct_pin_model (
  input  wire logic                          core_clk_in,
  output logic [dpct_pkg::NUM_PORT-1:0]      lines_out
);
  initial lines_out = 4'hF;
  // ======================================================================
  // slow pulses: 8 clocks each level so the pin synchronisers see every edge
  task automatic pulse(input int line, input int n);
    repeat (n) begin
      repeat (8) @(negedge core_clk_in);
      lines_out[line] = 1'b0;
      repeat (8) @(negedge core_clk_in);
      lines_out[line] = 1'b1;
    end
  endtask
  task automatic level(input logic v);
    @(negedge core_clk_in);
    lines_out[dpct_pkg::PIN_TIMER] = v;
  endtask
endmodule

// ---- dv/dpct_tb_top.sv ----
// self-checking bench for the dual counter/timer top
// assumes the pin model drives the port-three lines; inputs change at falling edges
`timescale 1ns/1ps
module dual_prescaled_counter_timers_tb_top;
  logic       core_clk_in, arst_n_in, t0_load_in, t1_load_in, t0_continuous_in, t1_continuous_in;
  logic [7:0] t0_load_value_in, t1_load_value_in, t0_count_out, t1_count_out, c;
  logic [5:0] t0_divisor_in, t1_divisor_in, request_mask_in, request_clear_in, request_pending_out;
  logic [1:0] t0_cmd_in, t1_cmd_in, t1_input_role_in;
  logic [3:0] port_three_request_lines_in;
  logic [2:0] interrupt_index_out;
  logic       input_mode_select_bit_in, cascade_in, request_global_enable_in;
  logic       t0_running_out, t1_running_out, interrupt_out;
  int         errors, n_checks;
  int         idx[4] = '{3, 2, 0, 1};

  dpct_top dpct_top_i (.core_clk_in, .arst_n_in, .t0_load_value_in, .t0_load_in, .t0_divisor_in,
    .t0_continuous_in, .t0_cmd_in, .t1_load_value_in, .t1_load_in, .t1_divisor_in, .t1_continuous_in,
    .t1_cmd_in, .input_mode_select_bit_in, .t1_input_role_in, .cascade_in, .port_three_request_lines_in,
    .request_mask_in, .request_global_enable_in, .request_clear_in, .t0_count_out, .t1_count_out,
    .t0_running_out, .t1_running_out, .request_pending_out, .interrupt_out, .interrupt_index_out);
  dpct_pin_model dpct_pin_model_i (.core_clk_in, .lines_out(port_three_request_lines_in));

  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  // ======================================================================
  // tasks
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic cmd(input int t, input logic [1:0] code);
    if (t == 0) t0_cmd_in = code;
    else t1_cmd_in = code;
    cyc(1);
    if (t == 0) t0_cmd_in = 2'h0;
    else t1_cmd_in = 2'h0;
  endtask
  task automatic load(input int t, input logic [7:0] v, input logic [5:0] d, input logic cont);
    if (t == 0) {t0_load_value_in, t0_divisor_in, t0_continuous_in, t0_load_in} = {v, d, cont, 1'b1};
    else {t1_load_value_in, t1_divisor_in, t1_continuous_in, t1_load_in} = {v, d, cont, 1'b1};
    cyc(1);
    if (t == 0) t0_load_in = 1'b0;
    else t1_load_in = 1'b0;
  endtask
  task automatic clear_all();
    request_clear_in = 6'h3F;
    cyc(1);
    request_clear_in = 6'h00;
  endtask
  // bounded wait: a request that never comes ends the run as a failure
  task automatic wait_req(input int b);
    int k;
    for (k = 0; k < 400 && request_pending_out[b] !== 1'b1; k++) cyc(1);
    if (k == 400) begin
      errors++;
      close_out();
    end
  endtask
  // ======================================================================
  // main sequence
  initial begin
    {t0_load_in, t1_load_in, t0_continuous_in, t1_continuous_in, cascade_in} = 5'h00;
    {t0_load_value_in, t1_load_value_in, t0_divisor_in, t1_divisor_in} = 28'h000_0000;
    {t0_cmd_in, t1_cmd_in, t1_input_role_in, request_mask_in, request_clear_in} = 18'h0_0000;
    {input_mode_select_bit_in, request_global_enable_in} = 2'b10;
    {errors, n_checks} = 0;
    arst_n_in = 1'b0;
    cyc(5);
    arst_n_in = 1'b1;
    check({t0_running_out, t1_running_out, request_pending_out}, 8'h00);
    load(0, 8'h02, 6'h01, 1'b0);
    check(t0_count_out, 8'h02);
    check(8'(t0_running_out), 8'h00);
    cmd(0, 2'h3);
    check(8'(t0_running_out), 8'h01);
    wait_req(4);
    check({t0_running_out, t0_count_out[6:0]}, 8'h00);
    cyc(20);
    check(t0_count_out, 8'h00);
    check(8'(interrupt_out), 8'h00);
    {request_mask_in, request_global_enable_in} = {6'h10, 1'b1};
    cyc(2);
    check({interrupt_out, interrupt_index_out}, 8'h0C);
    request_global_enable_in = 1'b0;
    cyc(2);
    check({interrupt_out, request_pending_out}, 8'h10);
    clear_all();
    check(8'(request_pending_out), 8'h00);
    // modulo-n reload, then stop, resume and restart
    load(0, 8'h03, 6'h01, 1'b1);
    cmd(0, 2'h3);
    wait_req(4);
    check({t0_running_out, t0_count_out[6:0]}, 8'h83);
    cmd(0, 2'h1);
    check(t0_count_out, 8'h03);
    cyc(30);
    check({t0_running_out, t0_count_out[6:0]}, 8'h03);
    cmd(0, 2'h2);
    cyc(8);
    check(t0_count_out, 8'h01);
    cmd(0, 2'h3);
    check(t0_count_out, 8'h03);
    // six internal ticks pass in 24 clocks, whatever the tick phase
    for (int d = 1; d <= 3; d++) begin
      load(0, 8'h09, 6'(d), 1'b0);
      cmd(0, 2'h3);
      cyc(24);
      check(t0_count_out, 8'(9 - 6 / d));
    end
    cmd(0, 2'h1);
    clear_all();
    // every port line sets its own request, masked one by one
    for (int i = 0; i < 4; i++) begin
      dpct_pin_model_i.pulse(i, 1);
      cyc(6);
      {request_mask_in, request_global_enable_in} = {~(6'h01 << idx[i]), 1'b1};
      cyc(2);
      check({interrupt_out, request_pending_out}, 8'(6'h01 << idx[i]));
      request_mask_in = 6'h01 << idx[i];
      cyc(2);
      check({interrupt_out, interrupt_index_out}, 8'(4'h8 | idx[i]));
      clear_all();
    end
    load(1, 8'h03, 6'h01, 1'b1);
    cmd(1, 2'h3);
    cyc(20);
    check({t1_running_out, t1_count_out[6:0]}, 8'h81);
    // external clock role counts falling pin edges
    {input_mode_select_bit_in, t1_input_role_in} = {dpct_pkg::EXT_MODE_ON, 2'h0};
    load(1, 8'h05, 6'h01, 1'b0);
    cmd(1, 2'h3);
    dpct_pin_model_i.pulse(1, 3);
    cyc(6);
    check(t1_count_out, 8'h02);
    t1_input_role_in = 2'h3;
    load(1, 8'h08, 6'h01, 1'b0);
    cmd(1, 2'h3);
    cyc(20);
    check(t1_count_out, 8'h03);
    dpct_pin_model_i.level(1'b0);
    cyc(6);
    c = t1_count_out;
    cyc(20);
    check(t1_count_out, c);
    dpct_pin_model_i.level(1'b1);
    // a second trigger reloads only in the retriggerable role
    for (int r = 1; r <= 2; r++) begin
      cmd(1, 2'h1);
      t1_input_role_in = 2'(r);
      load(1, 8'h40, 6'h01, 1'b0);
      dpct_pin_model_i.pulse(1, 1);
      cyc(4);
      check(8'(t1_running_out), 8'h01);
      cyc(40);
      dpct_pin_model_i.pulse(1, 1);
      cyc(4);
      check(8'(t1_count_out > 8'h38), 8'(r == 1));
    end
    cmd(1, 2'h1);
    {input_mode_select_bit_in, cascade_in} = 2'b11;
    clear_all();
    load(0, 8'h01, 6'h01, 1'b1);
    load(1, 8'h02, 6'h01, 1'b0);
    cmd(1, 2'h3);
    cmd(0, 2'h3);
    cyc(14);
    check({t1_running_out, request_pending_out[5], t1_count_out[5:0]}, 8'h40);
    arst_n_in = 1'b0;
    cyc(2);
    check({t0_running_out, t0_count_out[6:0]}, 8'h00);
    arst_n_in = 1'b1;
    cyc(2);
    close_out();
  end
endmodule
